// [core/lnb_supply_control_diag.sv]
// system control/status register and supply stage control of the lnb supply regulator
`default_nettype none
module lnb_supply_control_diag #(
    parameter int TICK_CYCLES = lnb_supply_pkg::TICK_CYCLES,
    parameter int ON_TICKS = lnb_supply_pkg::OVL_ON_TICKS,
    parameter int OFF_TICKS = lnb_supply_pkg::OVL_OFF_TICKS
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register access from the serial interface
    input wire logic wr_stb,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data_q,
    // control pins
    input wire logic fast_level_pin,
    input wire logic transmit_stage_pin,
    input wire logic tone_key_input,
    // analog monitor comparators
    input wire logic output_low_det,
    input wire logic tone_out_of_limit,
    input wire logic load_below_6ma,
    input wire logic load_below_12ma,
    input wire logic overload_det,
    input wire logic temp_above_150c,
    input wire logic temp_below_135c,
    // power stage controls
    output logic boost_en_q,
    output logic [lnb_supply_pkg::LEVEL_W-1:0] boost_output_mv_q,
    output logic regulator_en_q,
    output logic [lnb_supply_pkg::LEVEL_W-1:0] regulator_output_mv_q,
    output logic current_clamp_static_q,
    // tone stage controls
    output logic transmit_stage_en_q,
    output logic tone_gen_on_q
);
    import lnb_supply_pkg::*;

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    logic [7:0] ctl_q;
    logic enable;
    logic level_select;
    logic line_loss_comp;
    logic transmit_stage_en;
    logic continuous_tone_en;
    logic pulsed_limit_sel;
    logic test_threshold_sel;
    logic aux_test;

    // the whole byte is replaced on each write; no partial updates exist
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            ctl_q <= CTL_RESET;
        else if (wr_stb)
            ctl_q <= wr_data;
    end

    assign enable = ctl_q[CTL_ENABLE];
    assign level_select = ctl_q[CTL_LEVEL_SELECT];
    assign line_loss_comp = ctl_q[CTL_LINE_LOSS_COMP];
    assign transmit_stage_en = ctl_q[CTL_TRANSMIT_STAGE_EN];
    assign continuous_tone_en = ctl_q[CTL_CONTINUOUS_TONE_EN];
    assign pulsed_limit_sel = ctl_q[CTL_PULSED_LIMIT_SEL];
    assign test_threshold_sel = ctl_q[CTL_TEST_THRESHOLD_SEL];
    assign aux_test = ctl_q[CTL_AUX_TEST];

    // ------------------------------------------------------------
    // thermal protection
    // ------------------------------------------------------------
    logic thermal_q;

    // hysteresis: set above the hot point, held until the cool point
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            thermal_q <= 1'b0;
        else if (temp_above_150c)
            thermal_q <= 1'b1;
        else if (temp_below_135c)
            thermal_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // overload protection
    // ------------------------------------------------------------
    logic ovl_shut;
    logic ovl_flag;
    logic stages_active;

    assign stages_active = enable && !thermal_q;

    overload_cycler #(
        .TICK_CYCLES(TICK_CYCLES),
        .ON_TICKS(ON_TICKS),
        .OFF_TICKS(OFF_TICKS)
    ) u_overload (
        .ref_clk(ref_clk),
        .rst(rst),
        .active(stages_active),
        .static_mode(pulsed_limit_sel),
        .overload_det(overload_det),
        .shut_q(ovl_shut),
        .flag_q(ovl_flag)
    );

    // ------------------------------------------------------------
    // level targets
    // ------------------------------------------------------------
    logic [LEVEL_W-1:0] nominal_mv;
    logic [LEVEL_W-1:0] reg_mv_d;
    logic [LEVEL_W-1:0] boost_mv_d;

    always_comb
    begin
        nominal_mv = level_select ? MV_HIGH : MV_LOW;
        if (line_loss_comp)
            nominal_mv = nominal_mv + MV_COMP_STEP;
    end

    // the fast pin only acts with aux test off and the level select bit high;
    // pin low then pins the regulator to the low level
    always_comb
    begin
        if (aux_test)
            reg_mv_d = MV_AUX;
        else if (level_select && !fast_level_pin)
            reg_mv_d = MV_LOW;
        else
            reg_mv_d = nominal_mv;
    end

    // boost follows the register bits only, so a low fast pin burns
    // the extra headroom in the regulator; keep such periods short
    always_comb
    begin
        if (aux_test)
            boost_mv_d = MV_BOOST_AUX;
        else if (level_select)
            boost_mv_d = line_loss_comp ? MV_BOOST_HIGH + MV_COMP_STEP : MV_BOOST_HIGH;
        else
            boost_mv_d = nominal_mv + MV_BOOST_HEAD;
    end

    // ------------------------------------------------------------
    // power stage outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            boost_en_q <= 1'b0;
            regulator_en_q <= 1'b0;
            boost_output_mv_q <= MV_OFF;
            regulator_output_mv_q <= MV_OFF;
        end
        else
        begin
            boost_en_q <= stages_active;
            regulator_en_q <= stages_active && !ovl_shut;
            boost_output_mv_q <= stages_active ? boost_mv_d : MV_OFF;
            regulator_output_mv_q <= (stages_active && !ovl_shut) ? reg_mv_d : MV_OFF;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            current_clamp_static_q <= 1'b0;
        else
            current_clamp_static_q <= pulsed_limit_sel;
    end

    // ------------------------------------------------------------
    // tone stage outputs
    // ------------------------------------------------------------
    logic tx_stage_d;

    // pin or bit may open the transmit stage; standby overrides both
    assign tx_stage_d = enable && (transmit_stage_en || transmit_stage_pin);

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            transmit_stage_en_q <= 1'b0;
            tone_gen_on_q <= 1'b0;
        end
        else
        begin
            transmit_stage_en_q <= tx_stage_d;
            tone_gen_on_q <= tx_stage_d && (continuous_tone_en || tone_key_input);
        end
    end

    // ------------------------------------------------------------
    // diagnostic flags and status image
    // ------------------------------------------------------------
    logic [7:0] status_d;
    logic min_load_flag;
    logic voltage_monitor_flag;
    logic tone_monitor_flag;

    // the load check never sleeps; the host picks when to trust it
    assign min_load_flag = test_threshold_sel ? load_below_12ma : load_below_6ma;
    // valid only with compensation off; still reported raw otherwise
    assign voltage_monitor_flag = output_low_det;
    assign tone_monitor_flag = tone_out_of_limit;

    always_comb
    begin
        status_d = STS_RESET;
        status_d[STS_ENABLE_ECHO] = enable;
        status_d[STS_LEVEL_SELECT_ECHO] = level_select;
        status_d[STS_LINE_LOSS_ECHO] = line_loss_comp;
        status_d[STS_MIN_LOAD] = min_load_flag;
        status_d[STS_VOLTAGE_MON] = voltage_monitor_flag;
        status_d[STS_TONE_MON] = tone_monitor_flag;
        status_d[STS_THERMAL] = thermal_q;
        status_d[STS_OVERLOAD] = ovl_flag;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rd_data_q <= STS_RESET;
        else
            rd_data_q <= status_d;
    end
endmodule : lnb_supply_control_diag
`default_nettype wire

// [core/lnb_supply_pkg.sv]
// constants, bit layout and levels of the supply control and diagnostic block
`default_nettype none
package lnb_supply_pkg;
    // ------------------------------------------------------------
    // control byte layout (write side)
    // ------------------------------------------------------------
    localparam int CTL_ENABLE = 0;
    localparam int CTL_LEVEL_SELECT = 1;
    localparam int CTL_LINE_LOSS_COMP = 2;
    localparam int CTL_TRANSMIT_STAGE_EN = 3;
    localparam int CTL_CONTINUOUS_TONE_EN = 4;
    localparam int CTL_PULSED_LIMIT_SEL = 5;
    localparam int CTL_TEST_THRESHOLD_SEL = 6;
    localparam int CTL_AUX_TEST = 7;
    // ------------------------------------------------------------
    // status byte layout (read side)
    // ------------------------------------------------------------
    localparam int STS_ENABLE_ECHO = 0;
    localparam int STS_LEVEL_SELECT_ECHO = 1;
    localparam int STS_LINE_LOSS_ECHO = 2;
    localparam int STS_MIN_LOAD = 3;
    localparam int STS_VOLTAGE_MON = 4;
    localparam int STS_TONE_MON = 5;
    localparam int STS_THERMAL = 6;
    localparam int STS_OVERLOAD = 7;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] STS_RESET = 8'h00;
    // ------------------------------------------------------------
    // output level targets in millivolts
    // ------------------------------------------------------------
    localparam int LEVEL_W = 16;
    localparam logic [15:0] MV_OFF = 16'h0000;
    localparam logic [15:0] MV_LOW = 16'h32C8;       // 13000
    localparam logic [15:0] MV_HIGH = 16'h4650;      // 18000
    localparam logic [15:0] MV_AUX = 16'h55F0;       // 22000
    localparam logic [15:0] MV_COMP_STEP = 16'h03E8; // 1000
    localparam logic [15:0] MV_BOOST_HEAD = 16'h02EE; // 750
    localparam logic [15:0] MV_BOOST_HIGH = 16'h4B32; // 19250
    localparam logic [15:0] MV_BOOST_AUX = 16'h58DE;  // 22750
    // ------------------------------------------------------------
    // overload timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_NS = 1_000_000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int OVL_ON_MS = 90;
    localparam int OVL_OFF_MS = 900;
    localparam int TICK_MS = TICK_NS / 1_000_000;
    localparam int OVL_ON_TICKS = OVL_ON_MS / TICK_MS;
    localparam int OVL_OFF_TICKS = OVL_OFF_MS / TICK_MS;
    localparam int PRESCALE_W = 24;
    localparam int TICKS_W = 12;
endpackage : lnb_supply_pkg
`default_nettype wire

// [core/overload_cycler.sv]
// dynamic overload protection: on/off cycling timed from a fixed tick
`default_nettype none
module overload_cycler #(
    parameter int TICK_CYCLES = lnb_supply_pkg::TICK_CYCLES,
    parameter int ON_TICKS = lnb_supply_pkg::OVL_ON_TICKS,
    parameter int OFF_TICKS = lnb_supply_pkg::OVL_OFF_TICKS
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control and detection
    input wire logic active,
    input wire logic static_mode,
    input wire logic overload_det,
    // results
    output logic shut_q,
    output logic flag_q
);
    import lnb_supply_pkg::*;

    typedef enum logic [1:0] {OVL_IDLE, OVL_GRACE, OVL_OFF, OVL_RETRY} ovl_state_t;

    ovl_state_t state_q;
    ovl_state_t state_d;
    logic [PRESCALE_W-1:0] pre_q;
    logic [TICKS_W-1:0] ticks_q;
    logic seen_q;
    logic tick;
    logic on_done;
    logic off_done;

    assign tick = (pre_q == PRESCALE_W'(TICK_CYCLES - 1));
    assign on_done = tick && (ticks_q == TICKS_W'(ON_TICKS - 1));
    assign off_done = tick && (ticks_q == TICKS_W'(OFF_TICKS - 1));

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            OVL_IDLE:
                if (overload_det)
                    state_d = OVL_GRACE;
            OVL_GRACE:
                if (on_done)
                    state_d = (overload_det || seen_q) ? OVL_OFF : OVL_IDLE;
            OVL_OFF:
                if (off_done)
                    state_d = OVL_RETRY;
            OVL_RETRY:
                if (on_done)
                    state_d = (overload_det || seen_q) ? OVL_OFF : OVL_IDLE;
            default:
                state_d = OVL_IDLE;
        endcase
        if (!active || static_mode)
            state_d = OVL_IDLE;
    end

    // interval timer restarts on every state change so each interval is whole
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= OVL_IDLE;
            pre_q <= '0;
            ticks_q <= '0;
            seen_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (state_d != state_q)
            begin
                pre_q <= '0;
                ticks_q <= '0;
                seen_q <= 1'b0;
            end
            else
            begin
                pre_q <= tick ? '0 : pre_q + 1'b1;
                if (tick)
                    ticks_q <= ticks_q + 1'b1;
                if (overload_det && state_q != OVL_OFF)
                    seen_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            shut_q <= 1'b0;
            flag_q <= 1'b0;
        end
        else
        begin
            shut_q <= (state_d == OVL_OFF);
            if (static_mode)
                flag_q <= active && overload_det;
            else if (state_d == OVL_OFF)
                flag_q <= 1'b1;
            else if (state_d == OVL_IDLE)
                flag_q <= 1'b0;
        end
    end
endmodule : overload_cycler
`default_nettype wire

// [verif/lnb_supply_asserts.sv]
// concurrent checks on the ports of the supply control and diagnostic block
`default_nettype none
module lnb_supply_asserts
    import lnb_supply_pkg::*;
#(
    parameter int TICK_CYCLES = 4,
    parameter int ON_TICKS = 3,
    parameter int OFF_TICKS = 6
) (
    // clock, reset and register access
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr_stb,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data_q,
    // monitors
    input wire logic output_low_det,
    input wire logic tone_out_of_limit,
    input wire logic overload_det,
    input wire logic temp_above_150c,
    // stage controls
    input wire logic boost_en_q,
    input wire logic [lnb_supply_pkg::LEVEL_W-1:0] boost_output_mv_q,
    input wire logic regulator_en_q,
    input wire logic [lnb_supply_pkg::LEVEL_W-1:0] regulator_output_mv_q,
    input wire logic current_clamp_static_q,
    input wire logic transmit_stage_en_q,
    input wire logic tone_gen_on_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // dynamic overload entry
    // ------------------------------------------------------------
    sequence s_off_entry;
        !current_clamp_static_q ##0 $rose(rd_data_q[7]);
    endsequence
    // far shorter than the off interval, so it holds for any short count
    sequence s_held_off;
        !regulator_en_q [*8];
    endsequence
    // ------------------------------------------------------------
    // interval length counters
    // ------------------------------------------------------------
    // cycles the regulator has been off / on without a break
    localparam int OFF_LEN = OFF_TICKS * TICK_CYCLES;
    localparam int ON_LEN = ON_TICKS * TICK_CYCLES;
    logic [31:0] off_cnt;
    logic [31:0] on_cnt;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            off_cnt <= 32'h0000_0000;
        else if (regulator_en_q)
            off_cnt <= 32'h0000_0000;
        else
            off_cnt <= off_cnt + 32'h0000_0001;
    end
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            on_cnt <= 32'h0000_0000;
        else if (!regulator_en_q)
            on_cnt <= 32'h0000_0000;
        else
            on_cnt <= on_cnt + 32'h0000_0001;
    end
    AST_OFF_LEN: assert property ($rose(regulator_en_q) && rd_data_q[7] && !current_clamp_static_q
        |-> off_cnt == OFF_LEN)
        else $error("off interval length wrong");
    // first entry from grace is left out: the flag rises on that same edge
    AST_RETRY_LEN: assert property ($fell(regulator_en_q) && $past(rd_data_q[7]) && rd_data_q[0]
        && !rd_data_q[6] && !current_clamp_static_q |-> on_cnt == ON_LEN)
        else $error("retry interval length wrong");
    AST_ECHO: assert property (wr_stb |-> ##2 rd_data_q[2:0] == $past(wr_data[2:0], 2))
        else $error("echo bits differ from last write");
    AST_STANDBY: assert property (!rd_data_q[0] |->
        !boost_en_q && !regulator_en_q && regulator_output_mv_q == MV_OFF)
        else $error("stage active in standby");
    AST_LOW_LEVEL: assert property (regulator_en_q && !rd_data_q[1] && regulator_output_mv_q != MV_AUX
        |-> regulator_output_mv_q == (rd_data_q[2] ? MV_LOW + MV_COMP_STEP : MV_LOW))
        else $error("low level target wrong");
    AST_BOOST_PIN: assert property (boost_en_q && rd_data_q[1] && boost_output_mv_q != MV_BOOST_AUX
        |-> boost_output_mv_q == (rd_data_q[2] ? MV_BOOST_HIGH + MV_COMP_STEP : MV_BOOST_HIGH))
        else $error("boost target wrong");
    AST_AUX: assert property (regulator_output_mv_q == MV_AUX |-> boost_output_mv_q == MV_BOOST_AUX)
        else $error("aux boost target wrong");
    AST_VOLTAGE_MONITOR_FLAG: assert property (output_low_det |=> rd_data_q[4])
        else $error("voltage flag missing");
    AST_TONE: assert property (tone_out_of_limit |=> rd_data_q[5])
        else $error("tone flag missing");
    AST_THERMAL: assert property (temp_above_150c [*4] |-> rd_data_q[6] && !regulator_en_q && !boost_en_q)
        else $error("hot device not shut off");
    AST_STATIC: assert property (current_clamp_static_q [*3] |-> rd_data_q[7] == $past(overload_det, 2))
        else $error("static overload flag wrong");
    AST_DYN_OFF: assert property (s_off_entry |-> ##[0:1] s_held_off)
        else $error("output not shut on overload");
    AST_TONE_GEN: assert property (tone_gen_on_q |-> transmit_stage_en_q)
        else $error("tone without transmit stage");
endmodule : lnb_supply_asserts
bind lnb_supply_control_diag lnb_supply_asserts #(.TICK_CYCLES(TICK_CYCLES), .ON_TICKS(ON_TICKS),
    .OFF_TICKS(OFF_TICKS)) chk (.ref_clk, .rst, .wr_stb, .wr_data, .rd_data_q, .output_low_det,
    .tone_out_of_limit, .overload_det, .temp_above_150c, .boost_en_q, .boost_output_mv_q, .regulator_en_q,
    .regulator_output_mv_q, .current_clamp_static_q, .transmit_stage_en_q, .tone_gen_on_q);
`default_nettype wire

// [verif/lnb_host_model.sv]
// host side model: writes whole control bytes with a one-cycle strobe
`default_nettype none
module lnb_host_model (
    // clock
    input wire logic ref_clk,
    // register write
    output var logic wr_stb,
    output var logic [7:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        wr_stb = 1'b0;
        wr_data = 8'h00;
    end
    task automatic send(input logic [7:0] b);
        @(posedge ref_clk);
        wr_stb <= 1'b1;
        wr_data <= b;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
        // released data is not left looking valid
        wr_data <= ~b;
    endtask : send
endmodule : lnb_host_model
`default_nettype wire

// [verif/test_lnb_supply_control_diag.sv]
// self-checking bench of the supply control and diagnostic block
`default_nettype none
module test_lnb_supply_control_diag;
    timeunit 1ns;
    timeprecision 1ns;
    import lnb_supply_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic wr_stb, pin = 1'b1, tsp = 1'b0, key = 1'b0, low = 1'b0, tol = 1'b0, l6 = 1'b0, l12 = 1'b0;
    logic ovl = 1'b0, hot = 1'b0, cool = 1'b0;
    logic [7:0] wr_data, rd_data_q, b;
    logic [15:0] boost_mv, reg_mv;
    logic boost_en_q, regulator_en_q, current_clamp_static_q, transmit_stage_en_q, tone_gen_on_q;
    int mismatches = 0;
    int samples_checked = 0;
    always #50 ref_clk = ~ref_clk;
    lnb_host_model host (.ref_clk(ref_clk), .wr_stb(wr_stb), .wr_data(wr_data));
    lnb_supply_control_diag #(.TICK_CYCLES(4), .ON_TICKS(3), .OFF_TICKS(6)) uut (.ref_clk(ref_clk), .rst(rst),
        .wr_stb(wr_stb), .wr_data(wr_data), .rd_data_q(rd_data_q), .fast_level_pin(pin), .transmit_stage_pin(tsp),
        .tone_key_input(key), .output_low_det(low), .tone_out_of_limit(tol), .load_below_6ma(l6),
        .load_below_12ma(l12), .overload_det(ovl), .temp_above_150c(hot), .temp_below_135c(cool),
        .boost_en_q(boost_en_q), .boost_output_mv_q(boost_mv), .regulator_en_q(regulator_en_q),
        .regulator_output_mv_q(reg_mv), .current_clamp_static_q(current_clamp_static_q),
        .transmit_stage_en_q(transmit_stage_en_q), .tone_gen_on_q(tone_gen_on_q));
    // ------------------------------------------------------------
    // expectations and helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] exp_reg(input logic [7:0] c, input logic p);
        if (!c[0]) return MV_OFF;
        if (c[7]) return MV_AUX;
        if (c[1] && !p) return MV_LOW;
        return (c[1] ? MV_HIGH : MV_LOW) + (c[2] ? MV_COMP_STEP : 16'h0000);
    endfunction : exp_reg
    function automatic logic [15:0] exp_boost(input logic [7:0] c);
        if (!c[0]) return MV_OFF;
        if (c[7]) return MV_BOOST_AUX;
        return (c[1] ? MV_BOOST_HIGH : MV_LOW + MV_BOOST_HEAD) + (c[2] ? MV_COMP_STEP : 16'h0000);
    endfunction : exp_boost
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : settle
    task automatic wait_for(input bit on_flag, input logic v, input int lim);
        int n;
        n = 0;
        while ((on_flag ? rd_data_q[7] : regulator_en_q) !== v)
        begin
            settle(1);
            n++;
            if (n > lim)
            begin
                mismatches++;
                report_and_stop();
            end
        end
    endtask : wait_for
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'hb7532b85));
        settle(3);
        rst <= 1'b0;
        for (int i = 0; i < 60; i++)
        begin
            b = (i < 4) ? 8'h07 + 8'h80 * i[0] - 8'h02 * i[1] : 8'($urandom);
            if (!b[0]) b = 8'h00;
            @(posedge ref_clk);
            pin <= b[1] ? 1'($urandom) : 1'b1;
            {tsp, key, low, tol, l6, l12} <= 6'($urandom) & {b[0], 5'h1f};
            host.send(b);
            settle(3);
            check(rd_data_q[2:0], b[2:0]);
            check(reg_mv, exp_reg(b, pin));
            check(boost_mv, exp_boost(b));
            check({regulator_en_q, boost_en_q}, {2{b[0]}});
            check(current_clamp_static_q, b[5]);
            check(rd_data_q[5:4], {tol, low});
            if (!(b[3] | b[4] | tsp | key)) check(rd_data_q[3], b[6] ? l12 : l6);
            check({transmit_stage_en_q, tone_gen_on_q}, {2{b[0] & (b[3] | tsp)}} & {1'b1, b[4] | key});
        end
        @(posedge ref_clk);
        {pin, tsp, key, low, tol, l6, l12} <= 7'h40;
        host.send(8'h23);
        settle(3);
        check(rd_data_q[7:3], 5'h00);
        hot <= 1'b1;
        settle(5);
        check({rd_data_q[6], regulator_en_q, boost_en_q}, 3'b100);
        hot <= 1'b0;
        settle(5);
        check(rd_data_q[6], 1'b1);
        cool <= 1'b1;
        settle(5);
        check({rd_data_q[6], regulator_en_q}, 2'b01);
        cool <= 1'b0;
        ovl <= 1'b1;
        settle(4);
        check({rd_data_q[7], regulator_en_q}, 2'b11);
        ovl <= 1'b0;
        settle(4);
        check(rd_data_q[7], 1'b0);
        host.send(8'h03);
        settle(3);
        ovl <= 1'b1;
        wait_for(1'b1, 1'b1, 40);
        settle(2);
        check(regulator_en_q, 1'b0);
        wait_for(1'b0, 1'b1, 60);
        check(rd_data_q[7], 1'b1);
        wait_for(1'b0, 1'b0, 30);
        ovl <= 1'b0;
        wait_for(1'b1, 1'b0, 120);
        check(regulator_en_q, 1'b1);
        report_and_stop();
    end
endmodule : test_lnb_supply_control_diag
`default_nettype wire
